// [rtl/fpcu_pkg.sv]
// Constants, opcodes and security encodings of the flash programming command unit
package fpcu_pkg;
  // Flash organisation: 8 blocks of 1 KB, security word just above
  localparam int          FL_AW      = 13;
  localparam int          MEM_AW     = 14;
  localparam int          BLK_OFS_W  = 10;
  localparam logic [13:0] FL_SIZE    = 14'h2000;
  localparam logic [13:0] SEC_ADDR   = 14'h2000;
  localparam logic [12:0] FL_LAST    = 13'h1fff;
  localparam logic [12:0] BOOT_LAST  = 13'h0fff;
  localparam logic [7:0]  NUM_BLK    = 8'h08;
  localparam logic [7:0]  BLK_ALL    = 8'hff;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [9:0]  BLK_OFS_LO = 10'h000;
  localparam logic [9:0]  BLK_OFS_HI = 10'h3ff;

  // Link opcodes
  localparam logic [7:0] OP_RESET    = 8'h00;
  localparam logic [7:0] OP_VERIFY   = 8'h13;
  localparam logic [7:0] OP_CHIP_ER  = 8'h20;
  localparam logic [7:0] OP_BLK_ER   = 8'h22;
  localparam logic [7:0] OP_BLANK    = 8'h32;
  localparam logic [7:0] OP_PROGRAM  = 8'h40;
  localparam logic [7:0] OP_STATUS   = 8'h70;
  localparam logic [7:0] OP_SEC_SET  = 8'ha0;
  localparam logic [7:0] OP_CHECKSUM = 8'hb0;
  localparam logic [7:0] OP_SIGN     = 8'hc0;
  localparam logic [7:0] OP_VERSION  = 8'hc5;
  // Internal code for a self-programming block erase, never on the link
  localparam logic [7:0] OP_SELF_ER  = 8'hfe;

  // Responses
  localparam logic [7:0] RSP_ACK     = 8'h06;
  localparam logic [7:0] RSP_NAK     = 8'h15;

  // Security bit positions; stored word is active low, erased = permitted
  localparam int         SEC_CHIP    = 0;
  localparam int         SEC_BLK     = 1;
  localparam int         SEC_WR      = 2;
  localparam int         SEC_BOOT    = 3;
  localparam logic [7:0] SEC_CLR_MSK = 8'h06;
  localparam logic [3:0] SEC_NONE    = 4'h0;

  // Identity values, arbitrary
  localparam logic [7:0] SIG_ID      = 8'h5a;
  localparam logic [7:0] SIL_VER     = 8'h01;
  localparam logic [7:0] FW_VER      = 8'h10;

  localparam int         SYNC_N      = 3;
  localparam logic [1:0] ARGC_NONE   = 2'h0;
  localparam logic [1:0] ARGC_ONE    = 2'h1;
  localparam logic [1:0] ARGC_RANGE  = 2'h3;
  localparam logic [1:0] RSP_N_ONE   = 2'h1;
  localparam logic [1:0] RSP_N_TWO   = 2'h2;
  localparam logic [1:0] RSP_N_THREE = 2'h3;
endpackage

// [rtl/fpcu_mem.sv]
// Flash array model with security word; registered read data
module fpcu_mem (
  input  wire logic                         clk,
  input  wire logic                         we,
  input  wire logic [fpcu_pkg::MEM_AW-1:0]  addr,
  input  wire logic [7:0]                   wdata,
  output logic      [7:0]                   rdata_q
);
  // Array of twice the flash size, security word just above the flash; no reset so contents persist
  logic [7:0] mem [0:(1 << fpcu_pkg::MEM_AW) - 1];

  // Shipped state: all erased, every operation permitted
  initial
  begin
    for (int i = 0; i < (1 << fpcu_pkg::MEM_AW); i++)
      mem[i] = fpcu_pkg::ERASED;
  end

  // Single port: write or registered read
  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata_q <= mem[addr];
  end
endmodule // fpcu_mem

// [rtl/fpcu_top.sv]
// Command interpreter serving the external flash programmer
module fpcu_top (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PROG_MODE,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        TX_READY,
  input  wire logic        SELF_REQ,
  input  wire logic        SELF_ERASE,
  input  wire logic [12:0] SELF_ADDR,
  input  wire logic [7:0]  SELF_WDATA,
  input  wire logic        SELF_SEC_WR,
  input  wire logic [3:0]  SELF_SEC_DATA,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             PROG_ACTIVE,
  output logic             BUSY,
  output logic [3:0]       SEC_ACTIVE,
  output logic             SELF_DONE,
  output logic             SELF_OK
);
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_LDSEC = 7'h02,
    S_ARGS  = 7'h04,
    S_DATA  = 7'h08,
    S_SCAN  = 7'h10,
    S_SECWR = 7'h20,
    S_RESP  = 7'h40
  } fpcu_state_e;

  // Argument byte count per opcode
  function automatic logic [1:0] argc_of(input logic [7:0] op);
    unique case (op)
      fpcu_pkg::OP_VERIFY,
      fpcu_pkg::OP_PROGRAM:  argc_of = fpcu_pkg::ARGC_RANGE;
      fpcu_pkg::OP_BLK_ER,
      fpcu_pkg::OP_BLANK,
      fpcu_pkg::OP_CHECKSUM,
      fpcu_pkg::OP_SEC_SET:  argc_of = fpcu_pkg::ARGC_ONE;
      default:               argc_of = fpcu_pkg::ARGC_NONE;
    endcase
  endfunction

  // Opcode recognised on the link
  function automatic logic known_op(input logic [7:0] op);
    unique case (op)
      fpcu_pkg::OP_RESET, fpcu_pkg::OP_VERIFY, fpcu_pkg::OP_CHIP_ER,
      fpcu_pkg::OP_BLK_ER, fpcu_pkg::OP_BLANK, fpcu_pkg::OP_PROGRAM,
      fpcu_pkg::OP_STATUS, fpcu_pkg::OP_SEC_SET, fpcu_pkg::OP_CHECKSUM,
      fpcu_pkg::OP_SIGN, fpcu_pkg::OP_VERSION: known_op = 1'b1;
      default:                                 known_op = 1'b0;
    endcase
  endfunction

  // Address lies inside boot cluster 0
  function automatic logic in_boot(input logic [12:0] a);
    in_boot = (a <= fpcu_pkg::BOOT_LAST);
  endfunction

  // Pin synchroniser and filtered mode level
  logic [fpcu_pkg::SYNC_N-1:0] sync_q, sync_d;
  logic                        filt_q, filt_d;

  // Sequencer state
  fpcu_state_e st_q, st_d;
  logic [7:0]  op_q, op_d;          // Current command
  logic [1:0]  argc_q, argc_d;      // Argument bytes still due
  logic [23:0] args_q, args_d;      // Argument shift register
  logic [12:0] addr_q, addr_d;      // Data or scan pointer
  logic [12:0] last_q, last_d;      // Final scan address
  logic [7:0]  len_q, len_d;        // Data bytes still due
  logic        err_q, err_d;        // Command failed
  logic        rdp_q, rdp_d;        // Read issued last cycle
  logic        end_q, end_d;        // All scan reads issued
  logic [15:0] sum_q, sum_d;        // Running checksum
  logic [7:0]  cmp_q, cmp_d;        // Byte awaiting verify compare
  logic [7:0]  nv_q, nv_d;          // Shadow of stored security word
  logic [3:0]  act_q, act_d;        // Prohibitions in force
  logic        prog_q, prog_d;      // In programming mode
  logic [7:0]  rsp0_q, rsp0_d;      // Queued answer bytes
  logic [7:0]  rsp1_q, rsp1_d;
  logic [7:0]  rsp2_q, rsp2_d;
  logic [1:0]  rspn_q, rspn_d;      // Queued answer count
  logic        txv_q, txv_d;
  logic [7:0]  txd_q, txd_d;
  logic        busy_q, busy_d;
  logic        sdone_q, sdone_d;
  logic        sok_q, sok_d;

  // Memory port
  logic        mem_we;
  logic [13:0] mem_addr;
  logic [7:0]  mem_wd;
  logic [7:0]  mem_rd;

  // Scratch decode values
  logic [12:0] arg_a;
  logic [7:0]  arg_b;
  logic        whole;
  logic [15:0] nsum;
  logic        nerr;

  fpcu_mem u_mem (
    .clk     (CLK),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wd),
    .rdata_q (mem_rd)
  );

  // Next-state logic for the whole interpreter
  always_comb
  begin
    sync_d  = {sync_q[fpcu_pkg::SYNC_N-2:0], PROG_MODE};
    // Level changes only once the second and third stages agree
    filt_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : filt_q;
    st_d    = st_q;    op_d   = op_q;   argc_d = argc_q; args_d = args_q;
    addr_d  = addr_q;  last_d = last_q; len_d  = len_q;  err_d  = err_q;
    rdp_d   = rdp_q;   end_d  = end_q;  sum_d  = sum_q;  cmp_d  = cmp_q;
    nv_d    = nv_q;    act_d  = act_q;  prog_d = prog_q;
    rsp0_d  = rsp0_q;  rsp1_d = rsp1_q; rsp2_d = rsp2_q; rspn_d = rspn_q;
    txv_d   = txv_q & ~TX_READY;
    txd_d   = txd_q;
    sdone_d = 1'b0;
    sok_d   = sok_q;
    mem_we  = 1'b0;
    mem_addr = {1'b0, addr_q};
    mem_wd  = fpcu_pkg::ERASED;
    arg_a   = args_q[20:8];
    arg_b   = args_q[7:0];
    whole   = (args_q[7:0] == fpcu_pkg::BLK_ALL);
    nsum    = sum_q + {8'h00, mem_rd};
    nerr    = err_q | (mem_rd != fpcu_pkg::ERASED);
    unique case (st_q)
      // Fetch the stored security word after reset
      S_LDSEC:
      begin
        mem_addr = fpcu_pkg::SEC_ADDR;
        rdp_d    = ~rdp_q;
        if (rdp_q)
        begin
          nv_d = mem_rd;
          st_d = S_IDLE;
        end
      end
      S_IDLE:
      begin
        // Stored settings come into force only on mode entry
        if (!filt_q)
          prog_d = 1'b0;
        else if (!prog_q)
        begin
          prog_d = 1'b1;
          act_d  = ~nv_q[3:0];
        end
        // Only the programmer opens a transaction
        if (prog_q && filt_q && RX_VALID)
        begin
          op_d   = RX_DATA;
          argc_d = argc_of(RX_DATA);
          // Status must report the previous command's outcome, so it keeps the flag
          err_d  = (RX_DATA == fpcu_pkg::OP_STATUS) ? err_q : 1'b0;
          sum_d  = 16'h0000;
          end_d  = 1'b0;
          rdp_d  = 1'b0;
          if (known_op(RX_DATA))
            st_d = S_ARGS;
          else
          begin
            rsp0_d = fpcu_pkg::RSP_NAK;
            rspn_d = fpcu_pkg::RSP_N_ONE;
            st_d   = S_RESP;
          end
        end
        else if (!prog_q && SELF_REQ)
        begin
          // Self-programming obeys only boot protection
          sdone_d = 1'b1;
          sok_d   = 1'b0;
          if (!(~nv_q[fpcu_pkg::SEC_BOOT] && in_boot(SELF_ADDR)))
          begin
            if (SELF_ERASE)
            begin
              sdone_d = 1'b0;
              op_d    = fpcu_pkg::OP_SELF_ER;
              addr_d  = {SELF_ADDR[12:10], fpcu_pkg::BLK_OFS_LO};
              last_d  = {SELF_ADDR[12:10], fpcu_pkg::BLK_OFS_HI};
              st_d    = S_SCAN;
            end
            else
            begin
              mem_we   = 1'b1;
              mem_addr = {1'b0, SELF_ADDR};
              mem_wd   = SELF_WDATA;
              sok_d    = 1'b1;
            end
          end
        end
        else if (!prog_q && SELF_SEC_WR)
        begin
          // Self-programming may add prohibitions too
          nv_d   = nv_q & ~{4'h0, SELF_SEC_DATA};
          rspn_d = 2'h0;
          st_d   = S_SECWR;
        end
      end
      // Gather arguments, then judge the command
      S_ARGS:
      begin
        if (argc_q != fpcu_pkg::ARGC_NONE)
        begin
          if (RX_VALID)
          begin
            args_d = {args_q[15:0], RX_DATA};
            argc_d = argc_q - 2'h1;
          end
        end
        else
        begin
          rsp0_d = fpcu_pkg::RSP_ACK;
          rspn_d = fpcu_pkg::RSP_N_ONE;
          st_d   = S_RESP;
          unique case (op_q)
            fpcu_pkg::OP_VERIFY, fpcu_pkg::OP_PROGRAM:
            begin
              addr_d = arg_a;
              len_d  = arg_b;
              // Bad range still swallows its data, then refuses
              err_d  = (args_q[23:21] != 3'h0) || (arg_b == 8'h00) ||
                       (({1'b0, arg_a} + {6'h00, arg_b}) > fpcu_pkg::FL_SIZE);
              if (op_q == fpcu_pkg::OP_PROGRAM &&
                  (act_q[fpcu_pkg::SEC_WR] ||
                   (act_q[fpcu_pkg::SEC_BOOT] && in_boot(arg_a))))
                err_d = 1'b1;
              st_d   = S_DATA;
            end
            fpcu_pkg::OP_CHIP_ER:
            begin
              if (act_q[fpcu_pkg::SEC_CHIP] || act_q[fpcu_pkg::SEC_BOOT])
                rsp0_d = fpcu_pkg::RSP_NAK;
              else
              begin
                addr_d = 13'h0000;
                last_d = fpcu_pkg::FL_LAST;
                st_d   = S_SCAN;
              end
            end
            fpcu_pkg::OP_BLK_ER, fpcu_pkg::OP_BLANK, fpcu_pkg::OP_CHECKSUM:
            begin
              addr_d = whole ? 13'h0000 : {arg_b[2:0], fpcu_pkg::BLK_OFS_LO};
              last_d = whole ? fpcu_pkg::FL_LAST : {arg_b[2:0], fpcu_pkg::BLK_OFS_HI};
              if (!whole && arg_b >= fpcu_pkg::NUM_BLK)
                rsp0_d = fpcu_pkg::RSP_NAK;
              else if (op_q != fpcu_pkg::OP_BLK_ER)
                st_d = whole ? S_RESP : S_SCAN;
              else if (act_q[fpcu_pkg::SEC_BLK] ||
                       (whole && (act_q[fpcu_pkg::SEC_CHIP] ||
                                  act_q[fpcu_pkg::SEC_WR])) ||
                       (act_q[fpcu_pkg::SEC_BOOT] &&
                        (whole || in_boot({arg_b[2:0], fpcu_pkg::BLK_OFS_LO}))))
                rsp0_d = fpcu_pkg::RSP_NAK;
              else
                st_d = S_SCAN;
              if (whole && op_q != fpcu_pkg::OP_BLK_ER)
                rsp0_d = fpcu_pkg::RSP_NAK;
            end
            fpcu_pkg::OP_SEC_SET:
            begin
              // Bits only accumulate; nothing here can clear one
              nv_d = nv_q & ~{4'h0, arg_b[3:0]};
              st_d = S_SECWR;
            end
            fpcu_pkg::OP_STATUS:
            begin
              rsp1_d = {3'h0, err_q, act_q};
              rspn_d = fpcu_pkg::RSP_N_TWO;
            end
            fpcu_pkg::OP_SIGN:
            begin
              rsp1_d = fpcu_pkg::SIG_ID;
              rsp2_d = fpcu_pkg::NUM_BLK;
              rspn_d = fpcu_pkg::RSP_N_THREE;
            end
            fpcu_pkg::OP_VERSION:
            begin
              rsp1_d = fpcu_pkg::SIL_VER;
              rsp2_d = fpcu_pkg::FW_VER;
              rspn_d = fpcu_pkg::RSP_N_THREE;
            end
            default: ;  // Reset probe: plain acknowledge
          endcase
        end
      end
      // Data bytes of verify and programming
      S_DATA:
      begin
        if (len_q == 8'h00)
        begin
          rsp0_d = err_q ? fpcu_pkg::RSP_NAK : fpcu_pkg::RSP_ACK;
          rspn_d = fpcu_pkg::RSP_N_ONE;
          st_d   = S_RESP;
        end
        else if (rdp_q)
        begin
          if (mem_rd != cmp_q)
            err_d = 1'b1;
          rdp_d  = 1'b0;
          addr_d = addr_q + 13'h0001;
          len_d  = len_q - 8'h01;
        end
        else if (RX_VALID)
        begin
          if (op_q == fpcu_pkg::OP_VERIFY)
          begin
            cmp_d = RX_DATA;
            rdp_d = 1'b1;
          end
          else
          begin
            mem_we = ~err_q;
            mem_wd = RX_DATA;
            addr_d = addr_q + 13'h0001;
            len_d  = len_q - 8'h01;
          end
        end
      end
      // Erase writes, or pipelined reads for blank check and checksum
      S_SCAN:
      begin
        if (op_q == fpcu_pkg::OP_BLANK || op_q == fpcu_pkg::OP_CHECKSUM)
        begin
          rdp_d = ~end_q;
          if (!end_q)
          begin
            end_d  = (addr_q == last_q);
            addr_d = addr_q + 13'h0001;
          end
          if (rdp_q)
          begin
            sum_d = nsum;
            err_d = nerr;
          end
          if (rdp_q && end_q)
          begin
            rsp0_d = (op_q == fpcu_pkg::OP_BLANK && nerr) ?
                     fpcu_pkg::RSP_NAK : fpcu_pkg::RSP_ACK;
            rsp1_d = nsum[15:8];
            rsp2_d = nsum[7:0];
            rspn_d = (op_q == fpcu_pkg::OP_CHECKSUM) ? fpcu_pkg::RSP_N_THREE : fpcu_pkg::RSP_N_ONE;
            st_d   = S_RESP;
          end
        end
        else
        begin
          mem_we = 1'b1;
          addr_d = addr_q + 13'h0001;
          if (addr_q == last_q)
          begin
            st_d = S_RESP;
            if (op_q == fpcu_pkg::OP_SELF_ER)
            begin
              sdone_d = 1'b1;
              sok_d   = 1'b1;
              st_d    = S_IDLE;
            end
            else if (op_q == fpcu_pkg::OP_CHIP_ER)
            begin
              // A stored chip lock freezes every bit, even one set this session
              nv_d  = nv_q[fpcu_pkg::SEC_CHIP] ? (nv_q | fpcu_pkg::SEC_CLR_MSK) : nv_q;
              act_d = nv_q[fpcu_pkg::SEC_CHIP] ? (act_q & ~fpcu_pkg::SEC_CLR_MSK[3:0]) : act_q;
              st_d  = S_SECWR;
            end
          end
        end
      end
      // Persist the security word
      S_SECWR:
      begin
        mem_we   = 1'b1;
        mem_addr = fpcu_pkg::SEC_ADDR;
        mem_wd   = nv_q;
        st_d     = (rspn_q != 2'h0) ? S_RESP : S_IDLE;
      end
      // Hand queued answer bytes to the link
      S_RESP:
      begin
        if (!txv_q || TX_READY)
        begin
          if (rspn_q != 2'h0)
          begin
            txv_d  = 1'b1;
            txd_d  = rsp0_q;
            rsp0_d = rsp1_q;
            rsp1_d = rsp2_q;
            rspn_d = rspn_q - 2'h1;
          end
          else
            st_d = S_IDLE;
        end
      end
    endcase
    busy_d = (st_d != S_IDLE);
  end

  // State registers; security starts clear until the word is loaded
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync_q <= '0;  filt_q <= 1'b0;  st_q  <= S_LDSEC; op_q <= 8'h00;
      argc_q <= 2'h0; args_q <= 24'h000000; addr_q <= 13'h0000; last_q <= 13'h0000;
      len_q  <= 8'h00; err_q <= 1'b0; rdp_q <= 1'b0; end_q <= 1'b0;
      sum_q  <= 16'h0000; cmp_q <= 8'h00; nv_q <= fpcu_pkg::ERASED;
      act_q  <= fpcu_pkg::SEC_NONE; prog_q <= 1'b0;
      rsp0_q <= 8'h00; rsp1_q <= 8'h00; rsp2_q <= 8'h00; rspn_q <= 2'h0;
      txv_q  <= 1'b0; txd_q <= 8'h00; busy_q <= 1'b1; sdone_q <= 1'b0; sok_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d; filt_q <= filt_d; st_q <= st_d; op_q <= op_d;
      argc_q <= argc_d; args_q <= args_d; addr_q <= addr_d; last_q <= last_d;
      len_q  <= len_d;  err_q <= err_d;  rdp_q <= rdp_d;   end_q <= end_d;
      sum_q  <= sum_d;  cmp_q <= cmp_d;  nv_q <= nv_d;     act_q <= act_d;
      prog_q <= prog_d; rsp0_q <= rsp0_d; rsp1_q <= rsp1_d; rsp2_q <= rsp2_d;
      rspn_q <= rspn_d; txv_q <= txv_d;  txd_q <= txd_d;   busy_q <= busy_d;
      sdone_q <= sdone_d; sok_q <= sok_d;
    end
  end

  // Outputs straight from flip-flops
  assign TX_VALID    = txv_q;
  assign TX_DATA     = txd_q;
  assign PROG_ACTIVE = prog_q;
  assign BUSY        = busy_q;
  assign SEC_ACTIVE  = act_q;
  assign SELF_DONE   = sdone_q;
  assign SELF_OK     = sok_q;
endmodule // fpcu_top

// [tb/fpcu_chk.sv]
// Port-level checker of link answers, security and self-programming
module fpcu_chk (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic       TX_READY,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       PROG_ACTIVE,
  input wire logic       BUSY,
  input wire logic [3:0] SEC_ACTIVE,
  input wire logic       SELF_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Offered answer byte waits for the programmer
  a_tx_held_byte: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("answer byte dropped or changed");
  // Answers only inside programming mode
  a_tx_in_mode: assert property ($rose(TX_VALID) |-> PROG_ACTIVE)
    else $error("answer outside programming mode");
  a_probe_ack: assert property (RX_VALID && RX_DATA == fpcu_pkg::OP_RESET && PROG_ACTIVE && !BUSY
    |-> ##[1:8] TX_VALID && TX_DATA == fpcu_pkg::RSP_ACK) else $error("no acknowledge to probe");
  a_bad_op_nak: assert property (RX_VALID && RX_DATA == 8'h55 && PROG_ACTIVE && !BUSY
    |-> ##[1:8] TX_VALID && TX_DATA == fpcu_pkg::RSP_NAK) else $error("no refusal of unknown opcode");
  // Security only shrinks while the mode lasts; gains wait for re-entry
  a_sec_no_gain: assert property (PROG_ACTIVE && $past(PROG_ACTIVE) |-> (SEC_ACTIVE & ~$past(SEC_ACTIVE)) == 4'h0)
    else $error("prohibition took effect early");
  a_lock_frozen: assert property ($past(SEC_ACTIVE[0]) && PROG_ACTIVE && $past(PROG_ACTIVE) |-> $stable(SEC_ACTIVE))
    else $error("locked prohibitions changed");
  a_clear_cause: assert property (PROG_ACTIVE && $past(PROG_ACTIVE) && $fell(SEC_ACTIVE[2])
    |-> !SEC_ACTIVE[0] && !SEC_ACTIVE[3] && !SEC_ACTIVE[1]) else $error("prohibitions cleared wrongly");
  a_self_pulse: assert property (SELF_DONE |-> !PROG_ACTIVE ##1 !SELF_DONE)
    else $error("self completion malformed");
endmodule // fpcu_chk

bind fpcu_top fpcu_chk fpcu_chk_inst (.CLK(CLK), .RSTN(RSTN), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
  .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .PROG_ACTIVE(PROG_ACTIVE), .BUSY(BUSY),
  .SEC_ACTIVE(SEC_ACTIVE), .SELF_DONE(SELF_DONE));

// [tb/fpcu_prog.sv]
// Behavioural model of the external programmer on the byte link
module fpcu_prog (
  input  wire logic       CLK,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  output logic            RX_VALID,
  output logic [7:0]      RX_DATA,
  output logic            TX_READY
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0; // Hesitation before taking an answer
  initial
  begin
    RX_VALID = 1'b0;
    RX_DATA  = 8'h00;
    TX_READY = 1'b0;
  end
  // Only the programmer starts traffic; gap keeps byte spacing
  task automatic send(input logic [7:0] b);
    @(posedge CLK);
    RX_VALID <= 1'b1;
    RX_DATA  <= b;
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_DATA  <= ~b; // Idle line shows no stale byte
    @(posedge CLK);
  endtask
  // Take one answer byte; the bound covers a full-array erase
  task automatic get(output logic [7:0] b);
    int n;
    bit ok;
    ok = 1'b0;
    b = 8'h00;
    repeat (stall) @(posedge CLK);
    TX_READY <= 1'b1;
    for (n = 0; n < 20000 && !ok; n++)
    begin
      @(posedge CLK);
      if (TX_VALID === 1'b1)
      begin
        ok = 1'b1;
        b = TX_DATA;
      end
    end
    TX_READY <= 1'b0;
    @(posedge CLK);
  endtask
endmodule // fpcu_prog

// [tb/fpcu_top_tb.sv]
// Self-checking bench: programmer link, self-programming port, security
module fpcu_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ACK = fpcu_pkg::RSP_ACK;
  localparam logic [7:0] NAK = fpcu_pkg::RSP_NAK;
  logic CLK, RSTN, PROG_MODE, RX_VALID, TX_READY, SELF_REQ, SELF_ERASE, SELF_SEC_WR;
  logic TX_VALID, PROG_ACTIVE, BUSY, SELF_DONE, SELF_OK;
  logic [7:0]  RX_DATA, TX_DATA, SELF_WDATA;
  logic [12:0] SELF_ADDR;
  logic [3:0]  SELF_SEC_DATA, SEC_ACTIVE;
  int err_count = 0;
  int comparisons = 0;
  fpcu_top fpcu_top_inst (.CLK(CLK), .RSTN(RSTN), .PROG_MODE(PROG_MODE), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .TX_READY(TX_READY), .SELF_REQ(SELF_REQ), .SELF_ERASE(SELF_ERASE),
    .SELF_ADDR(SELF_ADDR), .SELF_WDATA(SELF_WDATA), .SELF_SEC_WR(SELF_SEC_WR),
    .SELF_SEC_DATA(SELF_SEC_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .PROG_ACTIVE(PROG_ACTIVE),
    .BUSY(BUSY), .SEC_ACTIVE(SEC_ACTIVE), .SELF_DONE(SELF_DONE), .SELF_OK(SELF_OK));
  fpcu_prog fpcu_prog_inst (.CLK(CLK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .TX_READY(TX_READY));
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command with its whole answer
  task automatic xfer(input logic [7:0] c[$], input logic [7:0] r[$]);
    logic [7:0] b;
    foreach (c[i]) fpcu_prog_inst.send(c[i]);
    foreach (r[i])
    begin
      fpcu_prog_inst.get(b);
      chk(b, r[i]);
    end
  endtask
  // Mode pin change, settled through the filter
  task automatic mode(input logic m);
    int n;
    PROG_MODE <= m;
    for (n = 0; n < 60 && !(PROG_ACTIVE === m && BUSY === 1'b0); n++) @(posedge CLK);
    chk({7'h00, PROG_ACTIVE}, {7'h00, m});
    chk({7'h00, BUSY}, 8'h00);
    @(posedge CLK);
  endtask
  task automatic self_op(input logic e, input logic [12:0] a, input logic ok);
    int n;
    SELF_REQ   <= 1'b1;
    SELF_ERASE <= e;
    SELF_ADDR  <= a;
    @(posedge CLK);
    SELF_REQ <= 1'b0;
    for (n = 0; n < 1200 && SELF_DONE !== 1'b1; n++) @(posedge CLK);
    chk({7'h00, SELF_DONE}, 8'h01);
    chk({7'h00, SELF_OK}, {7'h00, ok});
    @(posedge CLK);
    while (BUSY !== 1'b0) @(posedge CLK);
  endtask
  task automatic t_info();
    chk({4'h0, SEC_ACTIVE}, 8'h00);
    xfer('{8'h00}, '{ACK});
    xfer('{8'h70}, '{ACK, 8'h00});
    xfer('{8'hc0}, '{ACK, fpcu_pkg::SIG_ID, fpcu_pkg::NUM_BLK});
    xfer('{8'hc5}, '{ACK, fpcu_pkg::SIL_VER, fpcu_pkg::FW_VER});
    xfer('{8'h55}, '{NAK});
  endtask
  // Block 4 spans 1000h..13ffh; sum is 1022 erased bytes plus the two
  task automatic t_rw();
    fpcu_prog_inst.stall = 3;
    xfer('{8'h22, 8'h04}, '{ACK});
    xfer('{8'h32, 8'h04}, '{ACK});
    xfer('{8'h40, 8'h10, 8'h00, 8'h02, 8'ha5, 8'h3c}, '{ACK});
    xfer('{8'h13, 8'h10, 8'h00, 8'h02, 8'ha5, 8'h3c}, '{ACK});
    xfer('{8'h13, 8'h10, 8'h00, 8'h02, 8'ha5, 8'h3d}, '{NAK});
    xfer('{8'h70}, '{ACK, 8'h10});
    xfer('{8'h32, 8'h04}, '{NAK});
    xfer('{8'hb0, 8'h04}, '{ACK, 8'hfa, 8'he3});
    fpcu_prog_inst.stall = 0;
    xfer('{8'h20}, '{ACK});
    xfer('{8'h32, 8'h04}, '{ACK});
  endtask
  task automatic t_sec();
    xfer('{8'ha0, 8'h06}, '{ACK});
    chk({4'h0, SEC_ACTIVE}, 8'h00);
    mode(1'b0);
    mode(1'b1);
    chk({4'h0, SEC_ACTIVE}, 8'h06);
    xfer('{8'h40, 8'h10, 8'h00, 8'h01, 8'h11}, '{NAK});
    xfer('{8'h22, 8'h04}, '{NAK});
    mode(1'b0);
    self_op(1'b1, 13'h1000, 1'b1);
    self_op(1'b0, 13'h1004, 1'b1);
    mode(1'b1);
    xfer('{8'h13, 8'h10, 8'h00, 8'h05, 8'hff, 8'hff, 8'hff, 8'hff, 8'ha5}, '{ACK});
    mode(1'b0);
    mode(1'b1);
    xfer('{8'h20}, '{ACK});
    chk({4'h0, SEC_ACTIVE}, 8'h00);
  endtask
  // Boot guard set from the self side, then full lock
  task automatic t_boot();
    mode(1'b0);
    SELF_SEC_WR   <= 1'b1;
    SELF_SEC_DATA <= 4'h8;
    @(posedge CLK);
    SELF_SEC_WR <= 1'b0;
    repeat (4) @(posedge CLK);
    self_op(1'b0, 13'h0010, 1'b0);
    mode(1'b1);
    chk({4'h0, SEC_ACTIVE}, 8'h08);
    xfer('{8'h40, 8'h00, 8'h00, 8'h01, 8'h11}, '{NAK});
    xfer('{8'h40, 8'h10, 8'h00, 8'h01, 8'h11}, '{ACK});
    xfer('{8'h20}, '{NAK});
    xfer('{8'ha0, 8'h01}, '{ACK});
    mode(1'b0);
    mode(1'b1);
    chk({4'h0, SEC_ACTIVE}, 8'h09);
    xfer('{8'h20}, '{NAK});
    xfer('{8'h22, 8'hff}, '{NAK});
  endtask
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: two full erases plus two block erases fit well inside
  initial
  begin
    repeat (80000) @(posedge CLK);
    err_count++;
    stop_test();
  end
  initial
  begin
    RSTN = 1'b0;
    PROG_MODE = 1'b1;
    SELF_REQ = 1'b0;
    SELF_ERASE = 1'b0;
    SELF_ADDR = 13'h0000;
    SELF_WDATA = 8'ha5;
    SELF_SEC_WR = 1'b0;
    SELF_SEC_DATA = 4'h0;
    repeat (2) @(posedge CLK);
    chk({6'h00, TX_VALID, BUSY}, 8'h01);
    RSTN <= 1'b1;
    mode(1'b1);
    t_info();
    t_rw();
    t_sec();
    t_boot();
    stop_test();
  end
endmodule // fpcu_top_tb
